// ===== verilog/quhbp_defs.svh
// constants for the quad uart host bus port, types are in quhbp_pkg
`ifndef QUHBP_DEFS_SVH
`define QUHBP_DEFS_SVH

`define QUHBP_NUM_CHAN      4
`define QUHBP_ADDR_W        3
`define QUHBP_DATA_W        8
`define QUHBP_MODEM_CTRL_ADDR 3'h4
`define QUHBP_IRQ_OE_BIT      3
`define QUHBP_REG_RESET     8'h00

`endif

// ===== verilog/quhbp_pkg.sv
// types for the quad uart host bus port
package quhbp_pkg;
    typedef enum logic [1:0] {
        QUHBP_IDLE,
        QUHBP_READ,
        QUHBP_WRITE
    } quhbp_cycle_t;
endpackage

// ===== verilog/quhbp_chan_regs.sv
// per-channel register bank holding modem control and scratch registers
`timescale 1ns/100ps
`default_nettype none
`include "quhbp_defs.svh"
module quhbp_chan_regs #(
    parameter int ADDR_W = `QUHBP_ADDR_W,
    parameter int DATA_W = `QUHBP_DATA_W
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    // write port
    input  wire logic              wr_in,
    input  wire logic [ADDR_W-1:0] waddr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    // read port
    input  wire logic [ADDR_W-1:0] raddr_in,
    output logic      [DATA_W-1:0] rdata_out,
    // modem control output enable bit
    output logic                   irq_oe_bit_out
);
    // uart internals are outside this block; plain storage stands in for them
    logic [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < (1<<ADDR_W); i++) begin
                mem_r[i] <= `QUHBP_REG_RESET;
            end
        end else if (wr_in) begin
            mem_r[waddr_in] <= wdata_in;
        end
    end

    assign rdata_out      = mem_r[raddr_in];
    assign irq_oe_bit_out = mem_r[`QUHBP_MODEM_CTRL_ADDR][`QUHBP_IRQ_OE_BIT];
endmodule
`default_nettype wire

// ===== verilog/quhbp_host_port.sv
// host bus port of a four-channel uart: two bus styles and irq pin control
`timescale 1ns/100ps
`default_nettype none
`include "quhbp_defs.svh"
module quhbp_host_port #(
    parameter int NCH    = `QUHBP_NUM_CHAN,
    parameter int ADDR_W = `QUHBP_ADDR_W,
    parameter int DATA_W = `QUHBP_DATA_W
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    // bus style: high strobe style, low single-select style
    input  wire logic              strobe_style_in,
    // bus control
    input  wire logic              read_strobe_n_in,
    input  wire logic              write_strobe_n_in,
    input  wire logic              chan_a_select_n_in,
    input  wire logic              chan_b_select_n_in,
    input  wire logic              chan_c_select_n_in,
    input  wire logic              chan_d_select_n_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    // data bus, three signals
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe_n_out,
    // per-channel interrupt sources
    input  wire logic [NCH-1:0]    chan_irq_in,
    // interrupt control
    input  wire logic              irq_force_drive_in,
    // interrupt pins, level and active-low enable
    output logic                   chan_a_irq_out,
    output logic                   chan_a_irq_oe_n_out,
    output logic                   chan_b_irq_out,
    output logic                   chan_b_irq_oe_n_out,
    output logic                   chan_c_irq_out,
    output logic                   chan_c_irq_oe_n_out,
    output logic                   chan_d_irq_out,
    output logic                   chan_d_irq_oe_n_out
);
    // bus cycle state and the captured access
    quhbp_pkg::quhbp_cycle_t cyc_r;
    quhbp_pkg::quhbp_cycle_t cyc_nxt;
    logic [NCH-1:0]          sel_r;
    logic [ADDR_W-1:0]       addr_r;
    logic [DATA_W-1:0]       wdata_r;
    logic                    tgt_load;
    // decoded selects and strobes
    logic [NCH-1:0]          strobe_sel;
    logic [NCH-1:0]          single_sel;
    logic [NCH-1:0]          sel_nxt;
    logic                    any_sel;
    logic                    rd_act;
    logic                    wr_act;
    logic                    wr_commit;
    // register banks
    logic [NCH-1:0]          wr_en;
    logic [NCH-1:0]          oe_bit;
    logic [DATA_W-1:0]       rdata [NCH];
    logic [DATA_W-1:0]       rsel;
    // pin registers and their next values
    logic [DATA_W-1:0]       data_r;
    logic                    data_oe_n_r;
    logic [NCH-1:0]          irq_r;
    logic [NCH-1:0]          irq_nxt;
    logic [NCH-1:0]          irq_oe_n_r;
    logic [NCH-1:0]          irq_oe_n_nxt;
    logic [NCH-1:0]          strobe_oe_n;
    logic [NCH-1:0]          single_oe_n;
    logic                    any_irq;

    // channel number to one-hot select
    function automatic logic [NCH-1:0] onehot(input logic [1:0] n);
        onehot = '0;
        onehot[n] = 1'b1;
    endfunction

    // active-low pin to active-high flag
    function automatic logic asserted_n(input logic pin_n);
        asserted_n = !pin_n;
    endfunction

    // strobe style: one select pin for each channel
    always_comb begin
        strobe_sel    = '0;
        strobe_sel[0] = asserted_n(chan_a_select_n_in);
        strobe_sel[1] = asserted_n(chan_b_select_n_in);
        strobe_sel[2] = asserted_n(chan_c_select_n_in);
        strobe_sel[3] = asserted_n(chan_d_select_n_in);
    end

    // single-select style: a gates the device, c and b give the channel
    always_comb begin
        if (asserted_n(chan_a_select_n_in)) begin
            single_sel = onehot({chan_c_select_n_in, chan_b_select_n_in});
        end else begin
            single_sel = '0;
        end
    end

    // channel d select takes no part in single-select style
    always_comb begin
        if (strobe_style_in) begin
            sel_nxt = strobe_sel;
        end else begin
            sel_nxt = single_sel;
        end
        any_sel = |sel_nxt;
    end

    // read strobe ignored in single-select style
    always_comb begin
        if (strobe_style_in) begin
            rd_act = any_sel && asserted_n(read_strobe_n_in);
        end else begin
            rd_act = any_sel && write_strobe_n_in;
        end
    end

    // write low in both styles: strobe or direction level
    assign wr_act = any_sel && asserted_n(write_strobe_n_in);

    // cycle tracking; a write commits on the first edge its access is gone
    always_comb begin
        cyc_nxt = cyc_r;
        case (cyc_r)
            quhbp_pkg::QUHBP_IDLE: begin
                if (wr_act) begin
                    cyc_nxt = quhbp_pkg::QUHBP_WRITE;
                end else if (rd_act) begin
                    cyc_nxt = quhbp_pkg::QUHBP_READ;
                end
            end
            quhbp_pkg::QUHBP_READ: begin
                if (!rd_act) begin
                    cyc_nxt = quhbp_pkg::QUHBP_IDLE;
                end
            end
            quhbp_pkg::QUHBP_WRITE: begin
                if (!wr_act) begin
                    cyc_nxt = quhbp_pkg::QUHBP_IDLE;
                end
            end
            default: begin
                cyc_nxt = quhbp_pkg::QUHBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cyc_r <= quhbp_pkg::QUHBP_IDLE;
        end else begin
            cyc_r <= cyc_nxt;
        end
    end

    // target held once the write strobe is gone, for the commit
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sel_r <= '0;
        end else if (tgt_load) begin
            sel_r <= sel_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            addr_r <= '0;
        end else if (tgt_load) begin
            addr_r <= addr_in;
        end
    end

    // data may settle late in the strobe, so keep sampling while it is low
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wdata_r <= '0;
        end else if (wr_act) begin
            wdata_r <= data_in;
        end
    end

    assign wr_commit = (cyc_r == quhbp_pkg::QUHBP_WRITE) && !wr_act;
    assign tgt_load  = (cyc_r == quhbp_pkg::QUHBP_IDLE) || wr_act;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            assign wr_en[g] = wr_commit && sel_r[g];
            quhbp_chan_regs #(
                .ADDR_W (ADDR_W),
                .DATA_W (DATA_W)
            ) u_regs (
                .clk_in         (clk_in),
                .rstn_in        (rstn_in),
                .wr_in          (wr_en[g]),
                .waddr_in       (addr_r),
                .wdata_in       (wdata_r),
                .raddr_in       (addr_in),
                .rdata_out      (rdata[g]),
                .irq_oe_bit_out (oe_bit[g])
            );
        end
    endgenerate

    // rule out overlapping selects: lowest channel wins on a collision
    always_comb begin
        rsel = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (sel_nxt[i]) begin
                rsel = rdata[i];
            end
        end
    end

    // read data follows the live address; host samples at strobe rise
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            data_r <= '0;
        end else begin
            data_r <= rsel;
        end
    end

    // bus released the cycle after the read ends
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            data_oe_n_r <= 1'b1;
        end else begin
            data_oe_n_r <= !rd_act;
        end
    end

    // open drain: any channel request pulls the shared line
    assign any_irq = |chan_irq_in;

    always_comb begin
        if (strobe_style_in) begin
            irq_nxt = chan_irq_in;
        end else begin
            irq_nxt = '0;
        end
    end

    // force-drive overrides each channel's enable bit
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            strobe_oe_n[i] = !(irq_force_drive_in || oe_bit[i]);
        end
    end

    // unused b to d pins driven low, a only when pulled
    always_comb begin
        single_oe_n    = '0;
        single_oe_n[0] = !any_irq;
    end

    always_comb begin
        if (strobe_style_in) begin
            irq_oe_n_nxt = strobe_oe_n;
        end else begin
            irq_oe_n_nxt = single_oe_n;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_r <= '0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // pins float after reset until enabled
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_oe_n_r <= '1;
        end else begin
            irq_oe_n_r <= irq_oe_n_nxt;
        end
    end

    // data bus pins
    assign data_out            = data_r;
    assign data_oe_n_out       = data_oe_n_r;

    // interrupt pins
    assign chan_a_irq_out      = irq_r[0];
    assign chan_b_irq_out      = irq_r[1];
    assign chan_c_irq_out      = irq_r[2];
    assign chan_d_irq_out      = irq_r[3];
    assign chan_a_irq_oe_n_out = irq_oe_n_r[0];
    assign chan_b_irq_oe_n_out = irq_oe_n_r[1];
    assign chan_c_irq_oe_n_out = irq_oe_n_r[2];
    assign chan_d_irq_oe_n_out = irq_oe_n_r[3];
endmodule
`default_nettype wire

// ===== tb/quhbp_host_port_sva.sv
// assertions on the host bus port pins
`timescale 1ns/100ps
`default_nettype none
module quhbp_host_port_sva #(parameter int NCH = 4) (
    // clock, reset, style
    input wire logic           clk_in,
    input wire logic           rstn_in,
    input wire logic           strobe_style_in,
    // bus
    input wire logic           read_strobe_n_in,
    input wire logic           write_strobe_n_in,
    input wire logic           chan_a_select_n_in,
    input wire logic           data_oe_n_out,
    // interrupts
    input wire logic [NCH-1:0] chan_irq_in,
    input wire logic           irq_force_drive_in,
    input wire logic           chan_a_irq_out,
    input wire logic           chan_a_irq_oe_n_out,
    input wire logic           chan_b_irq_out,
    input wire logic           chan_b_irq_oe_n_out,
    input wire logic           chan_c_irq_out,
    input wire logic           chan_c_irq_oe_n_out,
    input wire logic           chan_d_irq_out,
    input wire logic           chan_d_irq_oe_n_out
);
    logic [3:0] lv;
    logic [3:0] oe;
    assign lv = {chan_d_irq_out, chan_c_irq_out, chan_b_irq_out, chan_a_irq_out};
    assign oe = {chan_d_irq_oe_n_out, chan_c_irq_oe_n_out, chan_b_irq_oe_n_out, chan_a_irq_oe_n_out};
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_rd_seen;
        strobe_style_in && !read_strobe_n_in && !chan_a_select_n_in;
    endsequence
    property p_rd_drv; s_rd_seen |=> !data_oe_n_out; endproperty
    property p_rd_rel; strobe_style_in && read_strobe_n_in |=> data_oe_n_out; endproperty
    property p_force; strobe_style_in && irq_force_drive_in |=> oe == 4'h0; endproperty
    property p_lvl; strobe_style_in |=> lv == $past(chan_irq_in); endproperty
    property p_ss_unused; !strobe_style_in |=> lv[3:1] == 3'h0 && oe[3:1] == 3'h0; endproperty
    property p_ss_shared; !strobe_style_in |=> !lv[0] && oe[0] == ($past(chan_irq_in) == 4'h0); endproperty
    property p_ss_rd; !strobe_style_in && !chan_a_select_n_in && write_strobe_n_in |=> !data_oe_n_out; endproperty
    property p_ss_wr; !strobe_style_in && (chan_a_select_n_in || !write_strobe_n_in) |=> data_oe_n_out; endproperty
    a_rd_drv: assert property (p_rd_drv) else $error("read not driven");
    a_rd_rel: assert property (p_rd_rel) else $error("bus held after read");
    a_force: assert property (p_force) else $error("force drive ignored");
    a_lvl: assert property (p_lvl) else $error("irq level wrong");
    a_ss_unused: assert property (p_ss_unused) else $error("unused irq not low");
    a_ss_shared: assert property (p_ss_shared) else $error("shared irq wrong");
    a_ss_rd: assert property (p_ss_rd) else $error("single read not driven");
    a_ss_wr: assert property (p_ss_wr) else $error("single write drove bus");
endmodule
bind quhbp_host_port quhbp_host_port_sva #(.NCH(NCH)) u_sva (.clk_in(clk_in), .rstn_in(rstn_in),
    .strobe_style_in(strobe_style_in), .read_strobe_n_in(read_strobe_n_in),
    .write_strobe_n_in(write_strobe_n_in), .chan_a_select_n_in(chan_a_select_n_in),
    .data_oe_n_out(data_oe_n_out), .chan_irq_in(chan_irq_in), .irq_force_drive_in(irq_force_drive_in),
    .chan_a_irq_out(chan_a_irq_out), .chan_a_irq_oe_n_out(chan_a_irq_oe_n_out),
    .chan_b_irq_out(chan_b_irq_out), .chan_b_irq_oe_n_out(chan_b_irq_oe_n_out),
    .chan_c_irq_out(chan_c_irq_out), .chan_c_irq_oe_n_out(chan_c_irq_oe_n_out),
    .chan_d_irq_out(chan_d_irq_out), .chan_d_irq_oe_n_out(chan_d_irq_oe_n_out));
`default_nettype wire

// ===== tb/quhbp_host_model.sv
// host processor model driving the parallel bus
`timescale 1ns/100ps
`default_nettype none
module quhbp_host_model (
    input  wire logic       clk_in,
    input  wire logic       style_in,
    input  wire logic [7:0] data_out_in,
    input  wire logic       data_oe_n_in,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic [3:0]      sel_n_out,
    output logic [2:0]      addr_out,
    output logic [7:0]      data_out
);
    initial begin
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        sel_n_out = 4'hF;
        addr_out = 3'h0;
        data_out = 8'h00;
    end
    // released bus shows the inverse so stale data never matches
    task automatic xfer(input logic rd, input logic [1:0] ch, input logic [2:0] a, input logic [7:0] wd,
                        output logic [7:0] q);
        @(posedge clk_in);
        addr_out <= a;
        data_out <= rd ? ~data_out : wd;
        wr_n_out <= rd;
        if (style_in) begin
            sel_n_out <= ~(4'h1 << ch);
            rd_n_out <= !rd;
        end else begin
            sel_n_out <= {1'b1, ch, 1'b0};
        end
        repeat (3) @(posedge clk_in);
        q = data_oe_n_in ? ~data_out_in : data_out_in;
        sel_n_out <= 4'hF;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        data_out <= ~data_out;
        repeat (2) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ===== tb/quhbp_host_port_tb_top.sv
// testbench for the host bus port
`timescale 1ns/100ps
`default_nettype none
module quhbp_host_port_tb_top;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       style = 1'b1;
    logic       frc = 1'b0;
    logic [3:0] irq = 4'h0;
    logic       rd_n, wr_n, doe_n;
    logic [3:0] sel_n, ilv, ioe;
    logic [2:0] addr;
    logic [7:0] hdata, ddata, q;
    int         err_total = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    always #5 clk = ~clk;
    quhbp_host_model host (.clk_in(clk), .style_in(style), .data_out_in(ddata), .data_oe_n_in(doe_n),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_n_out(sel_n), .addr_out(addr), .data_out(hdata));
    quhbp_host_port dut (.clk_in(clk), .rstn_in(rstn), .strobe_style_in(style), .read_strobe_n_in(rd_n),
        .write_strobe_n_in(wr_n), .chan_a_select_n_in(sel_n[0]), .chan_b_select_n_in(sel_n[1]),
        .chan_c_select_n_in(sel_n[2]), .chan_d_select_n_in(sel_n[3]), .addr_in(addr), .data_in(hdata),
        .data_out(ddata), .data_oe_n_out(doe_n), .chan_irq_in(irq), .irq_force_drive_in(frc),
        .chan_a_irq_out(ilv[0]), .chan_a_irq_oe_n_out(ioe[0]), .chan_b_irq_out(ilv[1]),
        .chan_b_irq_oe_n_out(ioe[1]), .chan_c_irq_out(ilv[2]), .chan_c_irq_oe_n_out(ioe[2]),
        .chan_d_irq_out(ilv[3]), .chan_d_irq_oe_n_out(ioe[3]));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic settle(input logic [3:0] oe_exp, input logic [3:0] lv_exp);
        repeat (2) @(posedge clk);
        #1;
        check("irq enables", {4'h0, ioe}, {4'h0, oe_exp});
        check("irq levels", {4'h0, ilv}, {4'h0, lv_exp});
    endtask
    // each channel gets its own byte, then all read back
    task automatic t_strobe;
        for (int i = 0; i < 4; i++) host.xfer(1'b0, 2'(i), 3'(i), 8'(8'hA0 + i), q);
        for (int i = 0; i < 4; i++) begin
            host.xfer(1'b1, 2'(i), 3'(i), 8'h00, q);
            check("strobe read", q, 8'(8'hA0 + i));
        end
        $display("test strobe done");
    endtask
    task automatic t_irq;
        @(posedge clk);
        irq <= 4'hF;
        host.xfer(1'b0, 2'h1, 3'h4, 8'h08, q);
        settle(4'hD, 4'hF);
        @(posedge clk);
        frc <= 1'b1;
        settle(4'h0, 4'hF);
        @(posedge clk);
        frc <= 1'b0;
        settle(4'hD, 4'hF);
        $display("test irq done");
    endtask
    // style switched only while the bus is idle
    task automatic t_single;
        @(posedge clk);
        style <= 1'b0;
        settle(4'h0, 4'h0);
        @(posedge clk);
        irq <= 4'h0;
        settle(4'h1, 4'h0);
        for (int i = 0; i < 4; i++) begin
            host.xfer(1'b1, 2'(i), 3'(i), 8'h00, q);
            check("single read", q, 8'(8'hA0 + i));
        end
        host.xfer(1'b0, 2'h3, 3'h6, 8'h5C, q);
        host.xfer(1'b1, 2'h3, 3'h6, 8'h00, q);
        check("single write", q, 8'h5C);
        $display("test single done");
    endtask
    // mid-run reset clears the banks, so enables float again
    task automatic t_reset;
        @(posedge clk);
        style <= 1'b1;
        rstn  <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        check("reset data enable", {7'h0, doe_n}, 8'h01);
        settle(4'hF, 4'h0);
        host.xfer(1'b1, 2'h0, 3'h0, 8'h00, q);
        check("reset clears", q, 8'h00);
        $display("test reset done");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        #1;
        check("data enable", {7'h0, doe_n}, 8'h01);
        check("irq default", {4'h0, ioe}, 8'h0F);
        t_strobe();
        t_irq();
        t_single();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
